/* File: logic/video_array_regs.vh */
// constants for the indirectly addressed video array
`ifndef VIDEO_ARRAY_REGS_VH
`define VIDEO_ARRAY_REGS_VH

// host i/o port addresses
`define VA_PORT_W             10
`define VA_INDEX_PORT         10'h3DA
`define VA_DATA_PORT          10'h3DE

// array indices
`define VA_IDX_MASK           8'h01
`define VA_IDX_BORDER         8'h02
`define VA_IDX_MODE           8'h03
`define VA_IDX_PAL_BASE       8'h10
`define VA_IDX_PAL_LAST       8'h1F
`define VA_IDX_PAL_HI         4'h1

// border colour fields (intensity, red, green, blue)
`define VA_BORDER_W           4
`define VA_BORDER_RESERVED    4'h0

// mode control field positions
`define VA_MODE_SIXTEEN       0
`define VA_MODE_FOUR_HIRES    1
`define VA_MODE_BORDER_EN     2
`define VA_MODE_ALT_LAYOUT    3
`define VA_MODE_W             4

// video status bits read at the index port
`define VA_STAT_DISP_OFF      0
`define VA_STAT_VRETRACE      3

// reset values
`define VA_RST_INDEX          8'h00
`define VA_RST_MASK           4'hF
`define VA_RST_BORDER         4'h0
`define VA_RST_MODE           4'h0
`define VA_RST_COLOUR         4'h0

`endif

/* File: logic/io_strobe_sync.v */
// two-flop synchroniser with rising edge pulse for host strobes
`default_nettype none

module io_strobe_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         srst_i,
  // asynchronous strobes
  input  wire [W-1:0] async_i,
  // synchronised level and its rising edge
  output reg  [W-1:0] level_o,
  output reg  [W-1:0] rise_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] prev_q;

  // first flop is only read by the second
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_q  <= {W{1'b0}};
      level_o <= {W{1'b0}};
      prev_q  <= {W{1'b0}};
      rise_o  <= {W{1'b0}};
    end else begin
      meta_q  <= async_i;
      level_o <= meta_q;
      prev_q  <= level_o;
      rise_o  <= level_o & ~prev_q;
    end
  end

endmodule // io_strobe_sync

`default_nettype wire

/* File: logic/colour_lookup_store.v */
// sixteen-entry four-bit colour lookup storage, write-only to the host
`default_nettype none

module colour_lookup_store #(
  parameter DEPTH = 16,
  parameter AW    = 4,
  parameter DW    = 4
) (
  // clock
  input  wire          clk_i,
  // host write side
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  // two read sides: pixel path and host-addressed entry
  input  wire [AW-1:0] pix_addr_i,
  output wire [DW-1:0] pix_data_o,
  input  wire [AW-1:0] host_addr_i,
  output wire [DW-1:0] host_data_o
);

  reg [DW-1:0] mem_q [0:DEPTH-1];

  // contents are undefined until loaded, as on the real part
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  assign pix_data_o  = mem_q[pix_addr_i];
  assign host_data_o = mem_q[host_addr_i];

endmodule // colour_lookup_store

`default_nettype wire

/* File: logic/video_array.v */
// video array: index/data host access, palette mask, border, lookup
`default_nettype none
`include "video_array_regs.vh"

module video_array #(
  parameter PAL_DEPTH = 16,
  parameter PAL_AW    = 4
) (
  // clock and reset
  input  wire                  MCLK_I,
  input  wire                  SRST_I,
  // host i/o bus, strobes are asynchronous pins
  input  wire [`VA_PORT_W-1:0] IO_ADDR_I,
  input  wire [7:0]            IO_DATA_I,
  input  wire                  IO_WR_I,
  input  wire                  IO_RD_I,
  output reg  [7:0]            IO_DATA_O,
  output reg                   IO_DATA_OE_N_O,
  // pixel stream from the fetch logic, same clock
  input  wire [3:0]            PIXEL_CODE_I,
  input  wire                  DISP_ACTIVE_I,
  input  wire                  VRETRACE_I,
  input  wire                  HIRES_GFX_I,
  input  wire                  GRAPHICS_I,
  input  wire [3:0]            LEGACY_BORDER_I,
  // colour output, retrace start pulse and pixel path configuration
  output reg  [3:0]            RGBI_O,
  output reg                   VRETRACE_IRQ_O,
  output reg                   SIXTEEN_COLOUR_O,
  output reg                   FOUR_HIRES_O,
  output reg                   ALT_LAYOUT_O
);

  // true when an array index falls in the lookup range
  function is_lookup_index;
    input [7:0] idx;
    begin
      is_lookup_index = (idx[7:4] == `VA_IDX_PAL_HI);
    end
  endfunction

  // forms the lookup address from a pixel code for the current mode
  function [3:0] lookup_address;
    input [3:0] code;
    input       sixteen;
    input       four_hires;
    input       alt_layout;
    input       hires;
    input       graphics;
    begin
      if (sixteen) begin
        lookup_address = code;
      end else if (four_hires && alt_layout) begin
        lookup_address = {2'h0, code[3:2]};
      end else if (four_hires) begin
        lookup_address = {2'h0, code[1:0]};
      end else if (hires && graphics) begin
        lookup_address = {3'h0, code[0]};
      end else if (graphics) begin
        lookup_address = {2'h0, code[1:0]};
      end else begin
        lookup_address = code;
      end
    end
  endfunction

  // synchronised host strobes
  wire [1:0] strobe_level;
  wire [1:0] strobe_rise;

  io_strobe_sync #(
    .W (2)
  ) u_strobe_sync (
    .clk_i   (MCLK_I),
    .srst_i  (SRST_I),
    .async_i ({IO_RD_I, IO_WR_I}),
    .level_o (strobe_level),
    .rise_o  (strobe_rise)
  );

  wire wr_rise  = strobe_rise[0];
  wire rd_level = strobe_level[1];

  // address and data are stable by the time the synced edge arrives
  wire hit_index_port = (IO_ADDR_I == `VA_INDEX_PORT);
  wire hit_data_port  = (IO_ADDR_I == `VA_DATA_PORT);
  wire wr_index       = wr_rise && hit_index_port;
  wire wr_data        = wr_rise && hit_data_port;

  // array registers
  reg [7:0]               index_q;
  reg [7:0]               index_d;
  reg [3:0]               mask_q;
  reg [3:0]               mask_d;
  reg [`VA_BORDER_W-1:0]  border_q;
  reg [`VA_BORDER_W-1:0]  border_d;
  reg [`VA_MODE_W-1:0]    mode_q;
  reg [`VA_MODE_W-1:0]    mode_d;
  reg                     pal_wr;

  // data port decode by current index
  always @* begin
    index_d = index_q;
    mask_d  = mask_q;
    border_d = border_q;
    mode_d  = mode_q;
    pal_wr  = 1'b0;
    if (wr_index) begin
      index_d = IO_DATA_I;
    end
    if (wr_data) begin
      case (index_q)
        `VA_IDX_MASK: begin
          mask_d = IO_DATA_I[3:0];
        end
        `VA_IDX_BORDER: begin
          border_d = IO_DATA_I[3:0];
        end
        `VA_IDX_MODE: begin
          // reserved bits are dropped; host keeps them zero anyway
          mode_d = IO_DATA_I[`VA_MODE_W-1:0];
        end
        default: begin
          pal_wr = is_lookup_index(index_q);
          // other indices fall through with nothing stored
        end
      endcase
    end
  end

  // register state
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      index_q  <= `VA_RST_INDEX;
      mask_q   <= `VA_RST_MASK;
      border_q <= `VA_RST_BORDER;
      mode_q   <= `VA_RST_MODE;
    end else begin
      index_q  <= index_d;
      mask_q   <= mask_d;
      border_q <= border_d;
      mode_q   <= mode_d;
    end
  end

  // mode control fields
  wire sixteen_sel = mode_q[`VA_MODE_SIXTEEN];
  wire four_hires  = mode_q[`VA_MODE_FOUR_HIRES];
  wire border_en   = mode_q[`VA_MODE_BORDER_EN];
  wire alt_layout  = mode_q[`VA_MODE_ALT_LAYOUT];

  // pixel path: mode selects address bits, then mask gates them
  wire [3:0] raw_addr = lookup_address(PIXEL_CODE_I, sixteen_sel,
                                       four_hires, alt_layout,
                                       HIRES_GFX_I, GRAPHICS_I);
  // mask register gates the selected address bits
  wire [3:0] masked_addr = raw_addr & mask_q;

  // lookup storage, one entry per index 10..1F
  wire [3:0] pix_colour;
  wire [3:0] host_colour;

  colour_lookup_store #(
    .DEPTH (PAL_DEPTH),
    .AW    (PAL_AW),
    .DW    (4)
  ) u_lookup (
    .clk_i       (MCLK_I),
    .wr_en_i     (pal_wr),
    .wr_addr_i   (index_q[PAL_AW-1:0]),
    .wr_data_i   (IO_DATA_I[3:0]),
    .pix_addr_i  (masked_addr[PAL_AW-1:0]),
    .pix_data_o  (pix_colour),
    .host_addr_i (index_q[PAL_AW-1:0]),
    .host_data_o (host_colour)
  );

  // loading shows the addressed entry until the index leaves the lookup range
  wire loading = is_lookup_index(index_q);

  // border source: own register when enabled, else legacy colour select
  wire [3:0] border_colour = border_en ? border_q
                                       : LEGACY_BORDER_I;

  // colour selection, registered so the output is a clean flop
  reg [3:0] rgbi_d;

  always @* begin
    if (loading) begin
      rgbi_d = host_colour;
    end else if (DISP_ACTIVE_I) begin
      rgbi_d = pix_colour;
    end else if (VRETRACE_I) begin
      // blank during retrace so the monitor sees black
      rgbi_d = `VA_RST_COLOUR;
    end else begin
      rgbi_d = border_colour;
    end
  end

  // entry bits map straight to blue, green, red, intensity lines
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      RGBI_O <= `VA_RST_COLOUR;
    end else begin
      RGBI_O <= rgbi_d;
    end
  end

  // pixel path configuration out to the fetch logic
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      SIXTEEN_COLOUR_O <= 1'b0;
      FOUR_HIRES_O     <= 1'b0;
      ALT_LAYOUT_O     <= 1'b0;
    end else begin
      SIXTEEN_COLOUR_O <= sixteen_sel;
      FOUR_HIRES_O     <= four_hires;
      ALT_LAYOUT_O     <= alt_layout;
    end
  end

  // retrace start pulse gives the host its window for loading
  reg vretrace_q;

  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      vretrace_q     <= 1'b0;
      VRETRACE_IRQ_O <= 1'b0;
    end else begin
      vretrace_q     <= VRETRACE_I;
      VRETRACE_IRQ_O <= VRETRACE_I & ~vretrace_q;
    end
  end

  // status byte at the index port; lookup entries never read back
  reg [7:0] status_d;

  always @* begin
    status_d = 8'h00;
    status_d[`VA_STAT_VRETRACE] = VRETRACE_I;
    status_d[`VA_STAT_DISP_OFF] = ~DISP_ACTIVE_I;
  end

  // read data drive; only the index port answers
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      IO_DATA_O      <= 8'h00;
      IO_DATA_OE_N_O <= 1'b1;
    end else if (rd_level && hit_index_port) begin
      IO_DATA_O      <= status_d;
      IO_DATA_OE_N_O <= 1'b0;
    end else begin
      // data port and array registers are write-only
      IO_DATA_O      <= 8'h00;
      IO_DATA_OE_N_O <= 1'b1;
    end
  end

endmodule // video_array

`default_nettype wire

/* File: tb/video_array_chk.sv */
// port checker for the video array
`default_nettype none
`include "video_array_regs.vh"
module video_array_chk (
  // clock and reset
  input wire logic                  MCLK_I,
  input wire logic                  SRST_I,
  // host bus
  input wire logic [`VA_PORT_W-1:0] IO_ADDR_I,
  input wire logic                  IO_WR_I,
  input wire logic                  IO_RD_I,
  input wire logic [7:0]            IO_DATA_O,
  input wire logic                  IO_DATA_OE_N_O,
  // pixel side
  input wire logic [3:0]            PIXEL_CODE_I,
  input wire logic                  DISP_ACTIVE_I,
  input wire logic                  VRETRACE_I,
  input wire logic                  HIRES_GFX_I,
  input wire logic                  GRAPHICS_I,
  input wire logic [3:0]            LEGACY_BORDER_I,
  input wire logic [3:0]            RGBI_O,
  input wire logic                  VRETRACE_IRQ_O,
  input wire logic                  SIXTEEN_COLOUR_O,
  input wire logic                  FOUR_HIRES_O,
  input wire logic                  ALT_LAYOUT_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  irq_on_rise_a: assert property ($rose(VRETRACE_I) |=> VRETRACE_IRQ_O)
    else $error("retrace pulse missing");
  irq_one_cycle_a: assert property (VRETRACE_IRQ_O |=> !VRETRACE_IRQ_O)
    else $error("retrace pulse too long");
  read_drive_a: assert property (($rose(IO_RD_I) &&
    IO_ADDR_I == `VA_INDEX_PORT) |-> ##[1:4] !IO_DATA_OE_N_O)
    else $error("status read not driven");
  read_refuse_a: assert property (($rose(IO_RD_I) &&
    IO_ADDR_I != `VA_INDEX_PORT) |-> IO_DATA_OE_N_O [*5])
    else $error("bus driven on refused read");
  bus_idle_a: assert property (!IO_RD_I [*4] |-> IO_DATA_OE_N_O)
    else $error("bus driven without read");
  // inputs held one cycle so the registered byte must match them
  status_live_a: assert property ((!IO_DATA_OE_N_O &&
    $stable(VRETRACE_I) && $stable(DISP_ACTIVE_I)) |->
    IO_DATA_O == {4'h0, VRETRACE_I, 2'b00, !DISP_ACTIVE_I})
    else $error("status byte wrong");
  mode_steady_a: assert property (!IO_WR_I [*5] |->
    $stable({SIXTEEN_COLOUR_O, FOUR_HIRES_O, ALT_LAYOUT_O}))
    else $error("mode changed without write");
  rgbi_steady_a: assert property ((!IO_WR_I [*5] ##0
    $stable({PIXEL_CODE_I, DISP_ACTIVE_I, VRETRACE_I, HIRES_GFX_I,
    GRAPHICS_I, LEGACY_BORDER_I})) |=> $stable(RGBI_O))
    else $error("colour changed without cause");
endmodule // video_array_chk
bind video_array video_array_chk chk_i (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
  .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I),
  .IO_DATA_O(IO_DATA_O), .IO_DATA_OE_N_O(IO_DATA_OE_N_O),
  .PIXEL_CODE_I(PIXEL_CODE_I), .DISP_ACTIVE_I(DISP_ACTIVE_I),
  .VRETRACE_I(VRETRACE_I), .HIRES_GFX_I(HIRES_GFX_I),
  .GRAPHICS_I(GRAPHICS_I), .LEGACY_BORDER_I(LEGACY_BORDER_I),
  .RGBI_O(RGBI_O), .VRETRACE_IRQ_O(VRETRACE_IRQ_O),
  .SIXTEEN_COLOUR_O(SIXTEEN_COLOUR_O), .FOUR_HIRES_O(FOUR_HIRES_O),
  .ALT_LAYOUT_O(ALT_LAYOUT_O));
`default_nettype wire

/* File: tb/host_io_model.sv */
// host processor model on the video array i/o ports
`default_nettype none
`include "video_array_regs.vh"
module host_io_model (
  // clock
  input  wire logic       clk_i,
  // i/o bus
  output var  logic [9:0] addr_o,
  output var  logic [7:0] data_o,
  output var  logic       wr_o,
  output var  logic       rd_o,
  input  wire logic [7:0] data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {addr_o, data_o, wr_o, rd_o} = 20'h00000;
  end
  // strobe held past the sync path; released lines carry junk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    {addr_o, data_o, wr_o} = {a, d, 1'b1};
    repeat (6) @(posedge clk_i);
    #1 {addr_o, data_o, wr_o} = {~a, ~d, 1'b0};
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // index first, then data to the indexed place
  task automatic put(input logic [7:0] idx, input logic [7:0] v);
    wr(`VA_INDEX_PORT, idx);
    wr(`VA_DATA_PORT, v);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    {addr_o, rd_o} = {a, 1'b1};
    repeat (5) @(posedge clk_i);
    #1 d = data_i;
    {addr_o, rd_o} = {~a, 1'b0};
    repeat (5) @(posedge clk_i);
    #1;
  endtask
endmodule // host_io_model
`default_nettype wire

/* File: tb/video_array_tb_top.sv */
// self-checking bench for the video array
`default_nettype none
`include "video_array_regs.vh"
module video_array_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk, srst, wr, rd, oe_n, disp, vr, hires, gfx, irq, six;
  logic       four, alt;
  logic [9:0] addr;
  logic [7:0] din, dout, st;
  logic [3:0] code, legacy, rgbi;
  int         err_count, checks, i;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  video_array uut (.MCLK_I(mclk), .SRST_I(srst), .IO_ADDR_I(addr),
    .IO_DATA_I(din), .IO_WR_I(wr), .IO_RD_I(rd), .IO_DATA_O(dout),
    .IO_DATA_OE_N_O(oe_n), .PIXEL_CODE_I(code), .DISP_ACTIVE_I(disp),
    .VRETRACE_I(vr), .HIRES_GFX_I(hires), .GRAPHICS_I(gfx),
    .LEGACY_BORDER_I(legacy), .RGBI_O(rgbi), .VRETRACE_IRQ_O(irq),
    .SIXTEEN_COLOUR_O(six), .FOUR_HIRES_O(four), .ALT_LAYOUT_O(alt));
  host_io_model host (.clk_i(mclk), .addr_o(addr), .data_o(din),
    .wr_o(wr), .rd_o(rd), .data_i(dout));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one cycle in, one registered cycle out
  task automatic pix(input logic [3:0] c);
    @(posedge mclk) #1 code = c;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  function automatic logic [3:0] sel(input logic [3:0] c, input int k);
    case (k)
      1: sel = {2'b00, c[1:0]};
      2: sel = {2'b00, c[3:2]};
      3: sel = {3'b000, c[0]};
      default: sel = c;
    endcase
  endfunction
  // entry n holds F-n, so every address shows up distinctly
  task automatic sweep(input logic [3:0] m, input int k);
    for (int c = 0; c < 16; c++) begin
      pix(c[3:0]);
      chk(rgbi, 4'hF - (sel(c[3:0], k) & m));
    end
  endtask
  task automatic summarize;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    summarize;
  end
  initial begin
    {srst, disp, vr, hires, gfx, code, legacy} = 13'h1006;
    {err_count, checks} = 0;
    repeat (6) @(posedge mclk);
    #1 {srst, vr} = 2'b01;
    host.rd(`VA_INDEX_PORT, st);
    chk(st, 8'h09);
    {disp, vr} = 2'b10;
    host.rd(`VA_INDEX_PORT, st);
    chk(st, 8'h00);
    host.rd(`VA_DATA_PORT, st);
    chk(st, 8'h00);
    // loading shows the addressed entry even in active display
    for (i = 0; i < 16; i++) begin
      host.put(`VA_IDX_PAL_BASE + i[7:0], 8'h0F - i[7:0]);
      pix(4'h0);
      chk(rgbi, 4'hF - i[3:0]);
    end
    host.put(`VA_IDX_MODE, 8'h01);
    chk(six, 1'b1);
    sweep(4'hF, 0);
    host.put(`VA_IDX_MASK, 8'h05);
    sweep(4'h5, 0);
    host.put(`VA_IDX_MASK, 8'h0F);
    host.put(`VA_IDX_MODE, 8'h02);
    chk(four, 1'b1);
    sweep(4'hF, 1);
    host.put(`VA_IDX_MODE, 8'h0A);
    chk(alt, 1'b1);
    sweep(4'hF, 2);
    host.put(`VA_IDX_MODE, 8'h00);
    {hires, gfx} = 2'b11;
    sweep(4'hF, 3);
    hires = 1'b0;
    sweep(4'hF, 1);
    {gfx, disp} = 2'b00;
    host.put(`VA_IDX_MODE, 8'h04);
    host.put(`VA_IDX_BORDER, 8'h0B);
    pix(4'h0);
    chk(rgbi, 4'hB);
    host.put(8'h00, 8'h0E);
    host.put(8'h05, 8'h0E);
    pix(4'h0);
    chk(rgbi, 4'hB);
    host.put(`VA_IDX_MODE, 8'h00);
    pix(4'h0);
    chk(rgbi, 4'h6);
    // retrace start: one-cycle pulse, then blank colour
    @(posedge mclk) #1 vr = 1'b1;
    @(posedge mclk) #1 chk(irq, 1'b1);
    @(posedge mclk) #1 chk(irq, 1'b0);
    chk(rgbi, 4'h0);
    summarize;
  end
endmodule // video_array_tb_top
`default_nettype wire
